//--- rtl/istpc_mon_if.sv
/*
 * Carrier between the slave core and the oscillator monitor.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface istpc_mon_if;
    logic scl_low;
    logic osc_off;
    logic bus_timeout;
    logic osc_stop_evt;
    modport mon (input scl_low, input osc_off, output bus_timeout, output osc_stop_evt);
    modport core (output scl_low, output osc_off, input bus_timeout, input osc_stop_evt);
endinterface : istpc_mon_if

//--- rtl/istpc_osc_mon.sv
/*
 * Oscillator monitor: samples the oscillator clock pin, detects a stopped
 * oscillator and a serial clock held low too long.
 * Assumes the oscillator pin is asynchronous to aclk.
 */
`timescale 1ns/1ns
module istpc_osc_mon #(
    parameter int OSF_CYCLES = istpc_pkg::OSF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_clk_i,
    istpc_mon_if.mon mon
);
    import istpc_pkg::*;

    localparam int SW = $clog2(OSF_CYCLES + 1);
    localparam int LW = $clog2(TMO_OSC_CYC + 1);

    if (OSF_CYCLES < 2) begin : g_chk_osf
        $error("OSF_CYCLES must be at least 2");
    end
    if (TMO_OSC_CYC > TMO_MAX_OSC_CYC) begin : g_chk_tmo
        $error("Timeout threshold exceeds the longest allowed time");
    end

    typedef struct packed {
        logic [2:0] osc_s;
        logic [SW-1:0] stop_cnt;
        logic stopped;
        logic [LW-1:0] low_cnt;
        logic fired;
        logic tmo;
        logic stop_evt;
    } istpc_mon_st_t;

    istpc_mon_st_t r;
    istpc_mon_st_t n;
    logic edge_seen;

    always_comb begin
        n = r;
        n.tmo = 1'b0;
        n.stop_evt = 1'b0;
        n.osc_s = {r.osc_s[1:0], osc_clk_i};
        edge_seen = r.osc_s[1] & ~r.osc_s[2];
        // Stop detection runs on aclk, as no oscillator edges arrive then
        if (edge_seen) begin
            n.stop_cnt = '0;
            n.stopped = 1'b0;
        end else if (!r.stopped) begin
            if (r.stop_cnt == SW'(OSF_CYCLES - 1)) begin
                n.stopped = 1'b1;
                n.stop_evt = 1'b1;
            end else begin
                n.stop_cnt = r.stop_cnt + SW'(1);
            end
        end
        // Low time counted in oscillator cycles, so no edges means no timeout
        if (!mon.scl_low || mon.osc_off) begin
            n.low_cnt = '0;
            n.fired = 1'b0;
        end else if (edge_seen && !r.fired) begin
            if (r.low_cnt == LW'(TMO_OSC_CYC - 1)) begin
                n.fired = 1'b1;
                n.tmo = 1'b1;
            end else begin
                n.low_cnt = r.low_cnt + LW'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign mon.bus_timeout = r.tmo;
    assign mon.osc_stop_evt = r.stop_evt;
endmodule : istpc_osc_mon

//--- rtl/istpc_pkg.sv
/*
 * Shared constants for the two-wire slave supervision block: register map,
 * field positions, reset values and timing figures.
 * Assumes a 20 MHz system clock and a 32.768 kHz oscillator clock.
 */
package istpc_pkg;
    // Register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_BUS_STATE = 8'h14;

    // Control register fields
    localparam int CTRL_OSC_DIS_BIT = 7;
    localparam int CTRL_ACE_BIT = 6;
    localparam int CTRL_PFS_BIT = 3;
    localparam int CTRL_RATE_LSB = 1;
    localparam int CTRL_AIE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h0e;

    // Status register fields
    localparam int STAT_OSF_BIT = 7;
    localparam int STAT_AF_BIT = 0;

    // Interrupt status, clear and enable layout
    localparam int IRQ_W = 3;
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_OSC_STOP_BIT = 1;
    localparam int IRQ_TIMEOUT_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Two-wire bus address; bit selected by the address pin is replaced
    localparam logic [6:0] SLAVE_ADDR = 7'h5a; // Arbitrary value
    localparam int ADDR_SEL_BIT = 0;

    // Timing
    localparam int CLK_HZ = 20000000;
    localparam int OSC_HZ = 32768;
    localparam int TMO_MIN_US = 25000;
    localparam int TMO_MAX_US = 35000;
    localparam int OSF_MS = 100;
    // Least time rounds up, longest rounds down
    localparam int TMO_OSC_CYC = (TMO_MIN_US * OSC_HZ + 999999) / 1000000;
    localparam int TMO_MAX_OSC_CYC = (TMO_MAX_US * OSC_HZ) / 1000000;
    localparam int OSF_CYC = OSF_MS * (CLK_HZ / 1000);
endpackage : istpc_pkg

//--- rtl/istpc_top.sv
/*
 * Two-wire slave front end with stuck-clock recovery, oscillator stop flag,
 * address pin matching and combined wave/interrupt pin, plus an AXI4-Lite
 * register slave.
 * Assumes pins are asynchronous to aclk, alarm_event and square_wave_in come
 * from logic on aclk, and an outside pad resolves open-drain enables.
 */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
// Operation
// - Recognise serial clock low beyond 25 ms.
// - Reset bus interface within 35 ms low.
// - Release data line on stuck clock.
// - Timeout works only with oscillator running.
// - Set oscillator stop flag after 100 ms.
// - Address bit must equal address pin.
// - Select bit picks wave or alarm interrupt.
// - Data and combined pin are open drain.
// - Alarm holds pin low until flag cleared.
// - Disable bit one stops the oscillator.

`timescale 1ns/1ns
module istpc_top #(
    parameter int OSF_CYCLES = istpc_pkg::OSF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic address_select_pin,
    input wire logic osc_clk_i,
    output logic osc_enable,
    input wire logic alarm_event,
    input wire logic square_wave_in,
    output logic [1:0] wave_rate,
    output logic alarm_counter_enable,
    output logic wave_or_irq_o,
    output logic wave_or_irq_oe,
    input wire logic [7:0] tx_byte,
    output logic rd_req,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic irq
);
    import istpc_pkg::*;

    typedef enum logic [2:0] {
        BS_IDLE, BS_ADDR, BS_ACK_A, BS_WDATA, BS_ACK_W, BS_RDATA, BS_RACK
    } istpc_bus_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] ad_s;
        istpc_bus_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic sda_drv;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rd_req;
        logic osc_dis;
        logic ace;
        logic pfs;
        logic [1:0] rate;
        logic alarm_irq_enable;
        logic oscillator_stop_flag;
        logic af;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_en;
        logic wave_low;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } istpc_st_t;

    istpc_st_t r;
    istpc_st_t n;
    istpc_mon_if mon_if ();

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic addr_match;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic ctrl_wr;
    logic stat_wr;

    istpc_osc_mon #(
        .OSF_CYCLES(OSF_CYCLES)
    ) u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_clk_i(osc_clk_i),
        .mon(mon_if.mon)
    );

    assign mon_if.scl_low = ~r.scl_s[1];
    assign mon_if.osc_off = r.osc_dis;

    always_comb begin
        n = r;
        n.rx_valid = 1'b0;
        n.rd_req = 1'b0;
        n.scl_s = {r.scl_s[1:0], scl_i};
        n.sda_s = {r.sda_s[1:0], sda_i};
        n.ad_s = {r.ad_s[0], address_select_pin};
        scl_rise = r.scl_s[1] & ~r.scl_s[2];
        scl_fall = ~r.scl_s[1] & r.scl_s[2];
        start_c = r.scl_s[1] & r.scl_s[2] & r.sda_s[2] & ~r.sda_s[1];
        stop_c = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[2] & r.sda_s[1];
        addr_match = (r.sh[7:1] & ~(7'h01 << ADDR_SEL_BIT)) == (SLAVE_ADDR & ~(7'h01 << ADDR_SEL_BIT))
            && r.sh[1 + ADDR_SEL_BIT] == r.ad_s[1];

        // Bus front end; stuck clock and stop both return it to idle
        if (mon_if.bus_timeout || stop_c) begin
            n.st = BS_IDLE;
            n.sda_drv = 1'b0;
        end else if (start_c) begin
            n.st = BS_ADDR;
            n.cnt = 4'h0;
            n.sda_drv = 1'b0;
        end else begin
            case (r.st)
                BS_IDLE: begin
                    n.sda_drv = 1'b0;
                end
                BS_ADDR, BS_WDATA: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], r.sda_s[1]};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == 4'h8) begin
                        if (r.st == BS_WDATA) begin
                            n.rx_data = r.sh;
                            n.rx_valid = 1'b1;
                            n.st = BS_ACK_W;
                            n.sda_drv = 1'b1;
                        end else if (addr_match) begin
                            n.rw = r.sh[0];
                            n.st = BS_ACK_A;
                            n.sda_drv = 1'b1;
                        end else begin
                            n.st = BS_IDLE;
                        end
                    end
                end
                BS_ACK_A, BS_ACK_W, BS_RACK: begin
                    if (scl_rise && r.st == BS_RACK && r.sda_s[1]) begin
                        n.st = BS_IDLE;
                    end else if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (r.st != BS_RACK && !(r.st == BS_ACK_A && r.rw)) begin
                            n.st = BS_WDATA;
                            n.sda_drv = 1'b0;
                        end else begin
                            n.st = BS_RDATA;
                            n.sh = tx_byte;
                            n.sda_drv = ~tx_byte[7];
                            n.rd_req = 1'b1;
                        end
                    end
                end
                BS_RDATA: begin
                    if (scl_rise) begin
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (r.cnt == 4'h8) begin
                            n.sda_drv = 1'b0;
                            n.st = BS_RACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.sda_drv = ~r.sh[6];
                        end
                    end
                end
                default: begin
                    n.st = BS_IDLE;
                    n.sda_drv = 1'b0;
                end
            endcase
        end

        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid && !r.aw_ok && !r.bvalid) begin
            n.aw_ok = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_ok && !r.bvalid) begin
            n.w_ok = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        ctrl_wr = 1'b0;
        stat_wr = 1'b0;
        irq_clr = '0;
        if (r.aw_ok && r.w_ok && !r.bvalid) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (r.aw_addr)
                ADDR_CTRL: ctrl_wr = r.w_strb[0];
                ADDR_STATUS: stat_wr = r.w_strb[0];
                ADDR_IRQ_CLEAR: irq_clr = r.w_strb[0] ? r.w_data[IRQ_W-1:0] : '0;
                ADDR_IRQ_ENABLE: n.irq_en = r.w_strb[0] ? r.w_data[IRQ_W-1:0] : r.irq_en;
                ADDR_IRQ_STATUS, ADDR_BUS_STATE: n.bresp = RESP_OKAY;
                default: n.bresp = RESP_SLVERR;
            endcase
        end else if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (ctrl_wr) begin
            n.osc_dis = r.w_data[CTRL_OSC_DIS_BIT];
            n.ace = r.w_data[CTRL_ACE_BIT];
            n.pfs = r.w_data[CTRL_PFS_BIT];
            n.rate = r.w_data[CTRL_RATE_LSB +: 2];
            n.alarm_irq_enable = r.w_data[CTRL_AIE_BIT];
        end

        // Flags clear on a written zero; a same-cycle event wins
        if (stat_wr && !r.w_data[STAT_OSF_BIT]) begin
            n.oscillator_stop_flag = 1'b0;
        end
        if (stat_wr && !r.w_data[STAT_AF_BIT]) begin
            n.af = 1'b0;
        end
        if (mon_if.osc_stop_evt) begin
            n.oscillator_stop_flag = 1'b1;
        end
        if (alarm_event) begin
            n.af = 1'b1;
        end
        irq_set = '0;
        irq_set[IRQ_ALARM_BIT] = alarm_event;
        irq_set[IRQ_OSC_STOP_BIT] = mon_if.osc_stop_evt;
        irq_set[IRQ_TIMEOUT_BIT] = mon_if.bus_timeout;
        n.irq_st = (r.irq_st & ~irq_clr) | irq_set;

        // Combined pin: alarm level or square wave, low side only
        n.wave_low = r.pfs ? (r.alarm_irq_enable & r.af) : ~square_wave_in;

        // AXI4-Lite read
        if (s_axi_arvalid && !r.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0;
            case (s_axi_araddr)
                ADDR_CTRL: begin
                    n.rdata[CTRL_OSC_DIS_BIT] = r.osc_dis;
                    n.rdata[CTRL_ACE_BIT] = r.ace;
                    n.rdata[CTRL_PFS_BIT] = r.pfs;
                    n.rdata[CTRL_RATE_LSB +: 2] = r.rate;
                    n.rdata[CTRL_AIE_BIT] = r.alarm_irq_enable;
                end
                ADDR_STATUS: begin
                    n.rdata[STAT_OSF_BIT] = r.oscillator_stop_flag;
                    n.rdata[STAT_AF_BIT] = r.af;
                end
                ADDR_IRQ_STATUS: n.rdata[IRQ_W-1:0] = r.irq_st;
                ADDR_IRQ_ENABLE: n.rdata[IRQ_W-1:0] = r.irq_en;
                ADDR_BUS_STATE: n.rdata[4:0] = {r.sda_drv, r.rw, r.st};
                ADDR_IRQ_CLEAR: n.rdata = 32'h0;
                default: n.rresp = RESP_SLVERR;
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.scl_s <= 3'h7;
            r.sda_s <= 3'h7;
            r.osc_dis <= CTRL_RESET[CTRL_OSC_DIS_BIT];
            r.ace <= CTRL_RESET[CTRL_ACE_BIT];
            r.pfs <= CTRL_RESET[CTRL_PFS_BIT];
            r.rate <= CTRL_RESET[CTRL_RATE_LSB +: 2];
            r.alarm_irq_enable <= CTRL_RESET[CTRL_AIE_BIT];
            r.irq_en <= IRQ_EN_RESET;
        end else begin
            r <= n;
        end
    end

    // Open-drain pins: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe = r.sda_drv;
    assign wave_or_irq_o = 1'b0;
    assign wave_or_irq_oe = r.wave_low;
    assign osc_enable = ~r.osc_dis;
    assign wave_rate = r.rate;
    assign alarm_counter_enable = r.ace;
    assign rd_req = r.rd_req;
    assign rx_data = r.rx_data;
    assign rx_valid = r.rx_valid;
    assign irq = |(r.irq_st & r.irq_en);

    assign s_axi_awready = ~r.aw_ok & ~r.bvalid;
    assign s_axi_wready = ~r.w_ok & ~r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = ~r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
endmodule : istpc_top

//--- testbench/istpc_mst.sv
/* Behavioural two-wire bus master, 1 us bit time.
   Assumes a pull-up on the data line resolved by the bench. */
`timescale 1ns/1ns
module istpc_mst (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam int HALF = 500;
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic start();
        sda_low <= 1'h0;
        scl <= 1'h1;
        #HALF;
        sda_low <= 1'h1;
        #HALF;
        scl <= 1'h0;
    endtask : start
    // Data moves only while the clock is low
    task automatic bit_out(input logic b);
        #(HALF/2);
        sda_low <= !b;
        #(HALF/2);
        scl <= 1'h1;
        #HALF;
        scl <= 1'h0;
    endtask : bit_out
    task automatic get_byte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            #HALF;
            scl <= 1'h1;
            #(HALF-100);
            v[i] = sda;
            #100;
            scl <= 1'h0;
        end
    endtask : get_byte
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bit_out(v[i]);
        end
    endtask : send_byte
    task automatic ack_clock(output logic a);
        #(HALF/2);
        sda_low <= 1'h0;
        #(HALF/2);
        scl <= 1'h1;
        #(HALF-100);
        a = !sda;
        #100;
        scl <= 1'h0;
    endtask : ack_clock
    task automatic stop();
        #(HALF/2);
        sda_low <= 1'h1;
        #(HALF/2);
        scl <= 1'h1;
        #HALF;
        sda_low <= 1'h0;
        #HALF;
    endtask : stop
endmodule : istpc_mst

//--- testbench/istpc_sva.sv
/* Checker for the two-wire slave supervision top.
   Sees only top-level ports; bound in at the foot. */
`timescale 1ns/1ns
module istpc_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    input wire logic osc_clk_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic osc_enable,
    input wire logic wave_or_irq_o,
    input wire logic irq
);
    import istpc_pkg::*;
    // Margin covers the pin synchronisers
    localparam int TMO_LIM = TMO_OSC_CYC + 2;
    logic osc_q_r;
    int lo_cnt_r;
    always_ff @(posedge aclk) begin
        osc_q_r <= osc_clk_i;
        if (!aresetn || scl_i || !osc_enable) begin
            lo_cnt_r <= 0;
        end else if (osc_clk_i && !osc_q_r) begin
            lo_cnt_r <= lo_cnt_r + 1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_sda_open_drain: assert property (sda_o == 1'h0)
        else $error("data pin driven high");
    a_pin_open_drain: assert property (wave_or_irq_o == 1'h0)
        else $error("combined pin driven high");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("data pulled while clock high");
    a_tmo_release: assert property (lo_cnt_r > TMO_LIM |-> !sda_oe)
        else $error("data held past timeout");
    a_osc_by_write: assert property ($changed(osc_enable) |-> $rose(s_axi_bvalid))
        else $error("oscillator changed without write");
    a_reset_idle: assert property ($rose(aresetn) |-> osc_enable && !sda_oe && !irq)
        else $error("bad state after reset");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule : istpc_sva
bind istpc_top istpc_sva istpc_sva_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .scl_i, .osc_clk_i, .sda_o, .sda_oe, .osc_enable,
    .wave_or_irq_o, .irq);

//--- testbench/tb.sv
/* Self-checking bench for the supervision top.
   Uses the checker bind and the two-wire master model. */
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb;
    import istpc_pkg::*;
    typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] data; logic [1:0] resp;} istpc_row_t;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, address_select_pin = 1'h0, osc_clk_i = 1'h0;
    logic alarm_event = 1'h0, square_wave_in = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_byte = 8'h00, rx_data, rx_last = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, wave_rate, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scl_i, sda_i, sda_o;
    logic sda_oe, wave_or_irq_o, wave_or_irq_oe, osc_enable, alarm_counter_enable, rd_req, rx_valid;
    logic irq, m_sda_low, a;
    logic [6:0] ad;
    int errors = 0, cmp_count = 0, rd_n = 0;
    istpc_row_t rows [8] = '{'{1'h0, ADDR_CTRL, {24'h0, CTRL_RESET}, RESP_OKAY},
        '{1'h0, ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY}, '{1'h0, ADDR_IRQ_CLEAR, 32'h0, RESP_OKAY},
        '{1'h0, 8'h18, 32'h0, RESP_SLVERR}, '{1'h1, 8'h18, 32'h0, RESP_SLVERR},
        '{1'h0, ADDR_BUS_STATE, 32'h0, RESP_OKAY},
        '{1'h1, ADDR_CTRL, 32'h7f, RESP_OKAY}, '{1'h0, ADDR_CTRL, 32'h4f, RESP_OKAY}};
    assign sda_i = !(sda_oe | m_sda_low);
    always #25 aclk = ~aclk;
    always begin
        #200;
        if (osc_enable === 1'h1) osc_clk_i = ~osc_clk_i;
    end
    always @(posedge aclk) if (rx_valid === 1'h1) rx_last <= rx_data;
    always @(posedge aclk) if (rd_req === 1'h1) rd_n <= rd_n + 1;
    istpc_top #(.OSF_CYCLES(2000)) istpc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_i, .sda_i, .sda_o, .sda_oe,
        .address_select_pin, .osc_clk_i, .osc_enable, .alarm_event, .square_wave_in, .wave_rate,
        .alarm_counter_enable, .wave_or_irq_o, .wave_or_irq_oe, .tx_byte, .rd_req, .rx_data,
        .rx_valid, .irq);
    istpc_mst istpc_mst_inst (.scl(scl_i), .sda_low(m_sda_low), .sda(sda_i));
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask : wt
    task automatic axi_wr(input logic [7:0] wa, input logic [31:0] wd, output logic [1:0] wr);
        int n;
        wt(1);
        s_axi_awaddr <= wa;
        s_axi_wdata <= wd;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            wt(1);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        if (n == 40) begin
            errors++;
            $display("[ERR] %0t write hung", $time);
            close_out();
        end
        wr = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] ra, output logic [31:0] rd, output logic [1:0] rr);
        int n;
        wt(1);
        s_axi_araddr <= ra;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            wt(1);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        if (n == 40) begin
            errors++;
            $display("[ERR] %0t read hung", $time);
            close_out();
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axi_rd
    initial begin
        wt(16);
        aresetn <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_wr(rows[i].addr, rows[i].data, r);
            end else begin
                axi_rd(rows[i].addr, d, r);
                `CHK(d, rows[i].data)
            end
            `CHK(r, rows[i].resp)
        end
        `CHK(wave_rate, 2'h3)
        `CHK(alarm_counter_enable, 1'h1)
        $display("register table done");
        alarm_event <= 1'h1;
        wt(1);
        alarm_event <= 1'h0;
        wt(20);
        `CHK(wave_or_irq_oe, 1'h1)
        `CHK(irq, 1'h0)
        axi_wr(ADDR_IRQ_ENABLE, 32'h1, r);
        wt(2);
        `CHK(irq, 1'h1)
        axi_wr(ADDR_STATUS, 32'h0, r);
        wt(3);
        `CHK(wave_or_irq_oe, 1'h0)
        axi_wr(ADDR_IRQ_CLEAR, 32'h1, r);
        wt(2);
        `CHK(irq, 1'h0)
        axi_wr(ADDR_CTRL, 32'h47, r);
        square_wave_in <= 1'h0;
        wt(3);
        `CHK(wave_or_irq_oe, 1'h1)
        square_wave_in <= 1'h1;
        wt(3);
        `CHK(wave_or_irq_oe, 1'h0)
        $display("pin and interrupt done");
        for (int i = 0; i < 4; i++) begin
            wt(1);
            address_select_pin <= i[1];
            wt(5);
            istpc_mst_inst.start();
            istpc_mst_inst.send_byte({SLAVE_ADDR[6:1], i[0], 1'h0});
            istpc_mst_inst.ack_clock(a);
            `CHK(a, i[0] == i[1])
            if (a) begin
                istpc_mst_inst.send_byte({6'h28, i[1:0]});
                istpc_mst_inst.ack_clock(a);
                `CHK(rx_last, {6'h28, i[1:0]})
            end
            istpc_mst_inst.stop();
        end
        $display("address match done");
        ad = {SLAVE_ADDR[6:1], 1'h1};
        tx_byte <= 8'h96;
        istpc_mst_inst.start();
        istpc_mst_inst.send_byte({ad, 1'h1});
        istpc_mst_inst.ack_clock(a);
        istpc_mst_inst.get_byte(d[7:0]);
        istpc_mst_inst.bit_out(1'h1);
        istpc_mst_inst.stop();
        `CHK(d[7:0], 8'h96)
        `CHK(rd_n, 1)
        axi_wr(ADDR_CTRL, 32'h88, r);
        wt(2);
        `CHK(osc_enable, 1'h0)
        wt(2100);
        axi_rd(ADDR_STATUS, d, r);
        `CHK(d, 32'h80)
        axi_rd(ADDR_IRQ_STATUS, d, r);
        `CHK(d, 32'h2)
        istpc_mst_inst.start();
        istpc_mst_inst.send_byte({ad, 1'h0});
        wt(6800);
        `CHK(sda_oe, 1'h1)
        istpc_mst_inst.ack_clock(a);
        istpc_mst_inst.stop();
        axi_wr(ADDR_CTRL, 32'h08, r);
        axi_wr(ADDR_STATUS, 32'h0, r);
        axi_wr(ADDR_IRQ_CLEAR, 32'h2, r);
        `CHK(osc_enable, 1'h1)
        $display("oscillator stop done");
        istpc_mst_inst.start();
        istpc_mst_inst.send_byte({ad, 1'h0});
        wt(6240);
        `CHK(sda_oe, 1'h1)
        wt(560);
        `CHK(sda_oe, 1'h0)
        axi_rd(ADDR_IRQ_STATUS, d, r);
        `CHK(d, 32'h4)
        istpc_mst_inst.stop();
        istpc_mst_inst.start();
        istpc_mst_inst.send_byte({ad, 1'h0});
        istpc_mst_inst.ack_clock(a);
        `CHK(a, 1'h1)
        istpc_mst_inst.stop();
        $display("timeout done");
        wt(1);
        aresetn <= 1'h0;
        wt(2);
        aresetn <= 1'h1;
        axi_rd(ADDR_CTRL, d, r);
        `CHK(d, {24'h0, CTRL_RESET})
        `CHK(osc_enable, 1'h1)
        $display("reset done");
        close_out();
    end
endmodule : tb
